//--- hw/tuning_regs_pkg.sv
// Package: offsets, field layout, reset values and timing of the tuning register bank
package tuning_regs_pkg;

  // Register access port
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;
  localparam logic [5:0] TRANSMIT_CONTROL_OFS     = 6'h15;
  localparam logic [5:0] RECEIVE_CONTROL_ZERO_OFS = 6'h16;
  localparam logic [5:0] RECEIVE_CONTROL_ONE_OFS  = 6'h17;

  // Values after reset
  localparam logic [15:0] TRANSMIT_CONTROL_RST     = 16'ha0ff;
  localparam logic [15:0] RECEIVE_CONTROL_ZERO_RST = 16'h12e5;
  localparam logic [15:0] RECEIVE_CONTROL_ONE_RST  = 16'h0a56;

  // Bits that store a write; top two receive bits are write-only and read zero
  localparam logic [15:0] TRANSMIT_CONTROL_MASK = 16'hffff;
  localparam logic [15:0] RECEIVE_CONTROL_MASK  = 16'h3fff;

  // Transmit control field positions
  localparam int unsigned TX_MIXER_BUFFER_BIAS_LSB = 14;
  localparam int unsigned TX_WAIT_SELECT_BIT       = 13;
  localparam int unsigned TX_MIXER_VARACTOR_LSB    = 11;
  localparam int unsigned TX_MIXER_BIAS_LSB        = 9;
  localparam int unsigned AMPLIFIER_BIAS_LSB       = 6;
  localparam int unsigned TX_RESERVED_ONE_BIT      = 5;
  localparam int unsigned OUTPUT_POWER_LEVEL_LSB   = 0;
  localparam logic [3:0]  AMPLIFIER_NOMINAL_CODE   = 4'h3;

  // Receive control zero field positions
  localparam int unsigned RX_MIXER_BUFFER_BIAS_LSB = 12;
  localparam int unsigned HIGH_COMP_LSB            = 10;
  localparam int unsigned MEDIUM_COMP_LSB          = 8;
  localparam int unsigned LOW_COMP_LSB             = 6;
  localparam int unsigned HIGH_AMP_BIAS_LSB        = 4;
  localparam int unsigned MEDIUM_AMP_BIAS_LSB      = 2;
  localparam int unsigned LOW_AMP_BIAS_LSB         = 0;

  // Receive control one field positions
  localparam int unsigned BANDPASS_LOW_BIAS_BIT     = 13;
  localparam int unsigned BANDPASS_MID_BIAS_BIT     = 12;
  localparam int unsigned LOW_REDUCED_GAIN_BIT      = 11;
  localparam int unsigned MEDIUM_REDUCED_GAIN_BIT   = 10;
  localparam int unsigned HIGH_MIXER_BOOST_BIT      = 9;
  localparam int unsigned MEDIUM_MIXER_BOOST_BIT    = 8;
  localparam int unsigned FRONT_AMP_VARACTOR_LSB    = 6;
  localparam int unsigned RX_MIXER_OUTPUT_BIAS_LSB  = 4;
  localparam int unsigned RX_MIXER_COMMON_MODE_LSB  = 2;
  localparam int unsigned RX_MIXER_BIAS_LSB         = 0;

  // Gain state of the receive gain control loop
  typedef enum logic [2:0] {
    GAIN_HIGH   = 3'b001,
    GAIN_MEDIUM = 3'b010,
    GAIN_LOW    = 3'b100
  } gain_state_t;

  // Turnaround timing
  localparam int unsigned CLK_PERIOD_NS      = 50;
  localparam int unsigned WAIT_SHORT_US      = 128;
  localparam int unsigned WAIT_LONG_US       = 192;
  localparam int unsigned WAIT_W             = 12;
  localparam logic [11:0] WAIT_SHORT_CYCLES  = 12'((WAIT_SHORT_US * 1000) / CLK_PERIOD_NS);
  localparam logic [11:0] WAIT_LONG_CYCLES   = 12'((WAIT_LONG_US * 1000) / CLK_PERIOD_NS);

  // Wait timer states
  typedef enum logic [1:0] {
    WAIT_IDLE = 2'b01,
    WAIT_RUN  = 2'b10
  } wait_state_t;

endpackage

//--- hw/tx_wait_timer.sv
// Transmit turnaround timer: delays the start of transmission after the transmit-on strobe
`timescale 1ns/10ps
`default_nettype none

module tx_wait_timer
  import tuning_regs_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic srst_i,
  // Control
  input  wire logic transmit_on_strobe_i,
  input  wire logic tx_wait_select_i,
  // Status
  output logic      tx_start_o,
  output logic      tx_waiting_o
);

  wait_state_t       state_q;
  logic [WAIT_W-1:0] count_q;
  logic              take;

  // A strobe during a wait is ignored rather than restarting the count
  assign take = transmit_on_strobe_i && (state_q == WAIT_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_q    <= WAIT_IDLE;
      count_q    <= '0;
      tx_start_o <= 1'b0;
    end else begin
      tx_start_o <= 1'b0;
      case (state_q)
        WAIT_IDLE: begin
          if (take) begin
            state_q <= WAIT_RUN;
            count_q <= tx_wait_select_i ? WAIT_LONG_CYCLES - 12'h001
                                        : WAIT_SHORT_CYCLES - 12'h001;
          end
        end
        WAIT_RUN: begin
          if (count_q == '0) begin
            state_q    <= WAIT_IDLE;
            tx_start_o <= 1'b1;
          end else begin
            count_q <= count_q - 12'h001;
          end
        end
        default: state_q <= WAIT_IDLE;
      endcase
    end
  end

  // Busy flag
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tx_waiting_o <= 1'b0;
    end else if (take) begin
      tx_waiting_o <= 1'b1;
    end else if (state_q == WAIT_RUN && count_q == '0) begin
      tx_waiting_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks: helper measures cycles from the taken strobe to the start pulse
  logic [WAIT_W-1:0] elapsed_q;
  logic              sel_seen_q;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      elapsed_q  <= '0;
      sel_seen_q <= 1'b0;
    end else if (take) begin
      elapsed_q  <= '0;
      sel_seen_q <= tx_wait_select_i;
    end else if (tx_waiting_o) begin
      // Counts the waiting cycles only, so it stops by itself at the start pulse
      elapsed_q <= elapsed_q + 12'h001;
    end
  end

  chk_wait_length: assert property (@(posedge mclk_i) disable iff (srst_i)
    tx_start_o |-> elapsed_q == (sel_seen_q ? WAIT_LONG_CYCLES : WAIT_SHORT_CYCLES))
    else $error("transmit start not at the selected turnaround time");

  chk_start_single: assert property (@(posedge mclk_i) disable iff (srst_i)
    tx_start_o |-> !tx_waiting_o ##1 !tx_start_o)
    else $error("transmit start pulse longer than one cycle");

  chk_wait_taken: assert property (@(posedge mclk_i) disable iff (srst_i)
    take |=> tx_waiting_o && !tx_start_o [*2])
    else $error("strobe not taken into the wait");

endmodule

`default_nettype wire

//--- hw/radio_tx_rx_tuning_regs.sv
// Transmit/receive tuning register bank with turnaround timer and gain-state field selection
`timescale 1ns/10ps
`default_nettype none

module radio_tx_rx_tuning_regs
  import tuning_regs_pkg::*;
(
  // Clock and reset
  input  wire logic                               mclk_i,
  input  wire logic                               srst_i,
  // Configuration port
  input  wire logic                               cfg_wr_i,
  input  wire logic                               cfg_rd_i,
  input  wire logic [tuning_regs_pkg::ADDR_W-1:0] cfg_addr_i,
  input  wire logic [tuning_regs_pkg::DATA_W-1:0] cfg_wdata_i,
  output logic      [tuning_regs_pkg::DATA_W-1:0] cfg_rdata_o,
  output logic                                    cfg_rvalid_o,
  // Transmit timing
  input  wire logic                               transmit_on_strobe_i,
  output logic                                    tx_start_o,
  output logic                                    tx_waiting_o,
  // Gain state from the gain control loop
  input  wire tuning_regs_pkg::gain_state_t       agc_gain_state_i,
  // Transmit analog settings
  output logic      [1:0]                         tx_mixer_buffer_bias_o,
  output logic      [1:0]                         tx_mixer_varactor_o,
  output logic      [1:0]                         tx_mixer_bias_o,
  output logic signed [3:0]                       amplifier_bias_adjust_o,
  output logic      [4:0]                         output_power_level_o,
  // Receive analog settings
  output logic      [1:0]                         rx_mixer_buffer_bias_o,
  output logic      [1:0]                         lna_compensation_o,
  output logic      [1:0]                         lna_amp_bias_o,
  output logic                                    lna_reduced_gain_o,
  output logic                                    rx_mixer_boost_o,
  output logic                                    bandpass_low_bias_o,
  output logic                                    bandpass_mid_bias_o,
  output logic      [1:0]                         front_amp_varactor_o,
  output logic      [1:0]                         rx_mixer_output_bias_o,
  output logic      [1:0]                         rx_mixer_common_mode_o,
  output logic      [1:0]                         rx_mixer_bias_o
);

  logic [15:0] transmit_control_q;
  logic [15:0] receive_control_zero_q;
  logic [15:0] receive_control_one_q;

  // Two-bit field fetch, used for many fields
  function automatic logic [1:0] field2(input logic [15:0] r, input int unsigned lsb);
    field2 = r[lsb +: 2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; masks drop write-only bits so they always read zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      transmit_control_q     <= TRANSMIT_CONTROL_RST;
      receive_control_zero_q <= RECEIVE_CONTROL_ZERO_RST;
      receive_control_one_q  <= RECEIVE_CONTROL_ONE_RST;
    end else if (cfg_wr_i) begin
      if (cfg_addr_i == TRANSMIT_CONTROL_OFS) begin
        transmit_control_q <= cfg_wdata_i & TRANSMIT_CONTROL_MASK;
      end else if (cfg_addr_i == RECEIVE_CONTROL_ZERO_OFS) begin
        receive_control_zero_q <= cfg_wdata_i & RECEIVE_CONTROL_MASK;
      end else if (cfg_addr_i == RECEIVE_CONTROL_ONE_OFS) begin
        receive_control_one_q <= cfg_wdata_i & RECEIVE_CONTROL_MASK;
      end
    end
  end

  // Read port: data one cycle after the read; unmapped addresses read zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cfg_rdata_o  <= '0;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
      if (!cfg_rd_i) begin
        cfg_rdata_o <= cfg_rdata_o;
      end else if (cfg_addr_i == TRANSMIT_CONTROL_OFS) begin
        cfg_rdata_o <= transmit_control_q;
      end else if (cfg_addr_i == RECEIVE_CONTROL_ZERO_OFS) begin
        cfg_rdata_o <= receive_control_zero_q;
      end else if (cfg_addr_i == RECEIVE_CONTROL_ONE_OFS) begin
        cfg_rdata_o <= receive_control_one_q;
      end else begin
        cfg_rdata_o <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Turnaround timer
  tx_wait_timer u_wait (
    .mclk_i               (mclk_i),
    .srst_i               (srst_i),
    .transmit_on_strobe_i (transmit_on_strobe_i),
    .tx_wait_select_i     (transmit_control_q[TX_WAIT_SELECT_BIT]),
    .tx_start_o           (tx_start_o),
    .tx_waiting_o         (tx_waiting_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit settings, registered so the analog side sees clean levels
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tx_mixer_buffer_bias_o  <= TRANSMIT_CONTROL_RST[TX_MIXER_BUFFER_BIAS_LSB +: 2];
      tx_mixer_varactor_o     <= TRANSMIT_CONTROL_RST[TX_MIXER_VARACTOR_LSB +: 2];
      tx_mixer_bias_o         <= TRANSMIT_CONTROL_RST[TX_MIXER_BIAS_LSB +: 2];
      amplifier_bias_adjust_o <= '0;
      output_power_level_o    <= TRANSMIT_CONTROL_RST[OUTPUT_POWER_LEVEL_LSB +: 5];
    end else begin
      tx_mixer_buffer_bias_o <= field2(transmit_control_q, TX_MIXER_BUFFER_BIAS_LSB);
      tx_mixer_varactor_o    <= field2(transmit_control_q, TX_MIXER_VARACTOR_LSB);
      tx_mixer_bias_o        <= field2(transmit_control_q, TX_MIXER_BIAS_LSB);
      // Code 3 is nominal, so the signed step is code minus three
      amplifier_bias_adjust_o <= signed'({1'b0, transmit_control_q[AMPLIFIER_BIAS_LSB +: 3]}
                                         - AMPLIFIER_NOMINAL_CODE);
      output_power_level_o   <= transmit_control_q[OUTPUT_POWER_LEVEL_LSB +: 5];
    end
  end

  // Receive settings that do not depend on the gain state
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rx_mixer_buffer_bias_o <= RECEIVE_CONTROL_ZERO_RST[RX_MIXER_BUFFER_BIAS_LSB +: 2];
      bandpass_low_bias_o    <= RECEIVE_CONTROL_ONE_RST[BANDPASS_LOW_BIAS_BIT];
      bandpass_mid_bias_o    <= RECEIVE_CONTROL_ONE_RST[BANDPASS_MID_BIAS_BIT];
      front_amp_varactor_o   <= RECEIVE_CONTROL_ONE_RST[FRONT_AMP_VARACTOR_LSB +: 2];
      rx_mixer_output_bias_o <= RECEIVE_CONTROL_ONE_RST[RX_MIXER_OUTPUT_BIAS_LSB +: 2];
      rx_mixer_common_mode_o <= RECEIVE_CONTROL_ONE_RST[RX_MIXER_COMMON_MODE_LSB +: 2];
      rx_mixer_bias_o        <= RECEIVE_CONTROL_ONE_RST[RX_MIXER_BIAS_LSB +: 2];
    end else begin
      rx_mixer_buffer_bias_o <= field2(receive_control_zero_q, RX_MIXER_BUFFER_BIAS_LSB);
      bandpass_low_bias_o    <= receive_control_one_q[BANDPASS_LOW_BIAS_BIT];
      bandpass_mid_bias_o    <= receive_control_one_q[BANDPASS_MID_BIAS_BIT];
      front_amp_varactor_o   <= field2(receive_control_one_q, FRONT_AMP_VARACTOR_LSB);
      rx_mixer_output_bias_o <= field2(receive_control_one_q, RX_MIXER_OUTPUT_BIAS_LSB);
      rx_mixer_common_mode_o <= field2(receive_control_one_q, RX_MIXER_COMMON_MODE_LSB);
      rx_mixer_bias_o        <= field2(receive_control_one_q, RX_MIXER_BIAS_LSB);
    end
  end

  // Per-gain-state set; states without a boost or reduced-gain bit drive zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lna_compensation_o <= '0;
      lna_amp_bias_o     <= '0;
      lna_reduced_gain_o <= 1'b0;
      rx_mixer_boost_o   <= 1'b0;
    end else begin
      case (agc_gain_state_i)
        GAIN_HIGH: begin
          lna_compensation_o <= field2(receive_control_zero_q, HIGH_COMP_LSB);
          lna_amp_bias_o     <= field2(receive_control_zero_q, HIGH_AMP_BIAS_LSB);
          lna_reduced_gain_o <= 1'b0;
          rx_mixer_boost_o   <= receive_control_one_q[HIGH_MIXER_BOOST_BIT];
        end
        GAIN_MEDIUM: begin
          lna_compensation_o <= field2(receive_control_zero_q, MEDIUM_COMP_LSB);
          lna_amp_bias_o     <= field2(receive_control_zero_q, MEDIUM_AMP_BIAS_LSB);
          lna_reduced_gain_o <= receive_control_one_q[MEDIUM_REDUCED_GAIN_BIT];
          rx_mixer_boost_o   <= receive_control_one_q[MEDIUM_MIXER_BOOST_BIT];
        end
        GAIN_LOW: begin
          lna_compensation_o <= field2(receive_control_zero_q, LOW_COMP_LSB);
          lna_amp_bias_o     <= field2(receive_control_zero_q, LOW_AMP_BIAS_LSB);
          lna_reduced_gain_o <= receive_control_one_q[LOW_REDUCED_GAIN_BIT];
          rx_mixer_boost_o   <= 1'b0;
        end
        // Illegal code: hold last applied set rather than glitch the front end
        default: begin
          lna_compensation_o <= lna_compensation_o;
          lna_amp_bias_o     <= lna_amp_bias_o;
          lna_reduced_gain_o <= lna_reduced_gain_o;
          rx_mixer_boost_o   <= rx_mixer_boost_o;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_tx_reset_value: assert property (@(posedge mclk_i)
    srst_i |=> transmit_control_q == 16'ha0ff && output_power_level_o == 5'h1f ##1
               output_power_level_o == 5'h1f)
    else $error("transmit control reset value wrong");

  chk_rx_reset_value: assert property (@(posedge mclk_i)
    srst_i |=> receive_control_zero_q == 16'h12e5 && receive_control_one_q == 16'h0a56)
    else $error("receive control reset value wrong");

  chk_amp_adjust_map: assert property (@(posedge mclk_i) disable iff (srst_i)
    ##1 amplifier_bias_adjust_o == $signed({1'b0, $past(transmit_control_q[8:6])}) - 4'sd3)
    else $error("amplifier adjustment not code minus three");

  chk_write_then_read: assert property (@(posedge mclk_i) disable iff (srst_i)
    cfg_wr_i && cfg_addr_i == 6'h16 ##1 cfg_rd_i && !cfg_wr_i && cfg_addr_i == 6'h16
    |=> cfg_rvalid_o && cfg_rdata_o == ($past(cfg_wdata_i, 2) & 16'h3fff))
    else $error("written value not read back");

  chk_rx_top_zero: assert property (@(posedge mclk_i) disable iff (srst_i)
    cfg_rvalid_o && $past(cfg_addr_i) == 6'h17 |-> cfg_rdata_o[15:14] == 2'h0)
    else $error("write-only bits read nonzero");

  chk_high_state_set: assert property (@(posedge mclk_i) disable iff (srst_i)
    agc_gain_state_i == GAIN_HIGH |=>
      lna_compensation_o == $past(receive_control_zero_q[11:10]) &&
      lna_amp_bias_o == $past(receive_control_zero_q[5:4]) && !lna_reduced_gain_o)
    else $error("high gain state set not applied");

  chk_low_state_set: assert property (@(posedge mclk_i) disable iff (srst_i)
    agc_gain_state_i == GAIN_LOW |=>
      lna_compensation_o == $past(receive_control_zero_q[7:6]) && !rx_mixer_boost_o &&
      lna_reduced_gain_o == $past(receive_control_one_q[11]))
    else $error("low gain state set not applied");

  // Helper: cycles left of a short turnaround, counted apart from the timer's own counter
  logic [WAIT_W-1:0] short_left_q;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      short_left_q <= '0;
    end else if (transmit_on_strobe_i && !tx_waiting_o && !transmit_control_q[13]) begin
      short_left_q <= WAIT_SHORT_CYCLES;
    end else if (short_left_q != '0) begin
      short_left_q <= short_left_q - 12'h001;
    end
  end

  chk_select_to_timer: assert property (@(posedge mclk_i) disable iff (srst_i)
    short_left_q == 12'h001 |=> tx_start_o)
    else $error("short turnaround not honoured");

endmodule

`default_nettype wire

//--- verification/tb_radio_tx_rx_tuning_regs.sv
// Self-checking bench for the transmit/receive tuning register bank
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t: mismatch got %h exp %h", $time, (a), (b)); end end

module tb_radio_tx_rx_tuning_regs;
  import tuning_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic               mclk_i               = 1'b0;
  logic               srst_i               = 1'b1;
  logic               cfg_wr_i             = 1'b0;
  logic               cfg_rd_i             = 1'b0;
  logic        [5:0]  cfg_addr_i           = 6'h00;
  logic        [15:0] cfg_wdata_i          = 16'h0000;
  logic               transmit_on_strobe_i = 1'b0;
  gain_state_t        agc_gain_state_i     = GAIN_HIGH;
  logic        [15:0] cfg_rdata_o;
  logic               cfg_rvalid_o, tx_start_o, tx_waiting_o;
  logic        [1:0]  tx_mixer_buffer_bias_o, tx_mixer_varactor_o, tx_mixer_bias_o;
  logic signed [3:0]  amplifier_bias_adjust_o;
  logic        [4:0]  output_power_level_o;
  logic        [1:0]  rx_mixer_buffer_bias_o, lna_compensation_o, lna_amp_bias_o;
  logic               lna_reduced_gain_o, rx_mixer_boost_o;
  logic               bandpass_low_bias_o, bandpass_mid_bias_o;
  logic        [1:0]  front_amp_varactor_o, rx_mixer_output_bias_o;
  logic        [1:0]  rx_mixer_common_mode_o, rx_mixer_bias_o;
  // Bench model of the three registers and the last legal gain state
  logic        [15:0] m [3];
  gain_state_t        lg;
  logic        [15:0] rnd = 16'h0013;
  logic        [5:0]  a;
  logic        [15:0] d;
  int                 n_mismatch = 0;
  int                 cmp_count  = 0;

  // 20 MHz clock
  always #25 mclk_i = ~mclk_i;

  radio_tx_rx_tuning_regs u_radio_tx_rx_tuning_regs (
    .mclk_i(mclk_i), .srst_i(srst_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_rvalid_o(cfg_rvalid_o), .transmit_on_strobe_i(transmit_on_strobe_i),
    .tx_start_o(tx_start_o), .tx_waiting_o(tx_waiting_o),
    .agc_gain_state_i(agc_gain_state_i), .tx_mixer_buffer_bias_o(tx_mixer_buffer_bias_o),
    .tx_mixer_varactor_o(tx_mixer_varactor_o), .tx_mixer_bias_o(tx_mixer_bias_o),
    .amplifier_bias_adjust_o(amplifier_bias_adjust_o),
    .output_power_level_o(output_power_level_o),
    .rx_mixer_buffer_bias_o(rx_mixer_buffer_bias_o), .lna_compensation_o(lna_compensation_o),
    .lna_amp_bias_o(lna_amp_bias_o), .lna_reduced_gain_o(lna_reduced_gain_o),
    .rx_mixer_boost_o(rx_mixer_boost_o), .bandpass_low_bias_o(bandpass_low_bias_o),
    .bandpass_mid_bias_o(bandpass_mid_bias_o), .front_amp_varactor_o(front_amp_varactor_o),
    .rx_mixer_output_bias_o(rx_mixer_output_bias_o),
    .rx_mixer_common_mode_o(rx_mixer_common_mode_o), .rx_mixer_bias_o(rx_mixer_bias_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers: random source, bus cycles, expectations

  // Sixteen-bit shift register, fixed start so runs repeat
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Top two receive bits are not stored, so the model drops them too
  function automatic void model_wr(input logic [5:0] ad, input logic [15:0] dv);
    if (ad == 6'h15) m[0] = dv;
    else if (ad == 6'h16) m[1] = dv & 16'h3fff;
    else if (ad == 6'h17) m[2] = dv & 16'h3fff;
  endfunction

  task automatic wr(input logic [5:0] ad, input logic [15:0] dv);
    @(negedge mclk_i);
    cfg_wr_i    = 1'b1;
    cfg_addr_i  = ad;
    cfg_wdata_i = dv;
    @(negedge mclk_i);
    cfg_wr_i = 1'b0;
    model_wr(ad, dv);
  endtask

  task automatic rd(input logic [5:0] ad, input logic [15:0] ev);
    @(negedge mclk_i);
    cfg_rd_i   = 1'b1;
    cfg_addr_i = ad;
    @(negedge mclk_i);
    cfg_rd_i = 1'b0;
    // Valid stands for one cycle only, right after the read edge
    `CHK(cfg_rvalid_o, 1'b1)
    `CHK(cfg_rdata_o, ev)
  endtask

  // Compare every field output with the model, two cycles after the last change
  task automatic check_fields();
    logic [1:0] ec;
    logic [1:0] ea;
    logic       er;
    logic       eb;
    repeat (2) @(negedge mclk_i);
    `CHK(tx_mixer_buffer_bias_o, m[0][15:14])
    `CHK(tx_mixer_varactor_o, m[0][12:11])
    `CHK(tx_mixer_bias_o, m[0][10:9])
    `CHK(amplifier_bias_adjust_o, 4'(m[0][8:6]) - 4'h3)
    `CHK(output_power_level_o, m[0][4:0])
    `CHK(rx_mixer_buffer_bias_o, m[1][13:12])
    `CHK(bandpass_low_bias_o, m[2][13])
    `CHK(bandpass_mid_bias_o, m[2][12])
    `CHK(front_amp_varactor_o, m[2][7:6])
    `CHK(rx_mixer_output_bias_o, m[2][5:4])
    `CHK(rx_mixer_common_mode_o, m[2][3:2])
    `CHK(rx_mixer_bias_o, m[2][1:0])
    case (lg)
      GAIN_HIGH: begin
        ec = m[1][11:10]; ea = m[1][5:4]; er = 1'b0; eb = m[2][9];
      end
      GAIN_MEDIUM: begin
        ec = m[1][9:8]; ea = m[1][3:2]; er = m[2][10]; eb = m[2][8];
      end
      default: begin
        ec = m[1][7:6]; ea = m[1][1:0]; er = m[2][11]; eb = 1'b0;
      end
    endcase
    `CHK(lna_compensation_o, ec)
    `CHK(lna_amp_bias_o, ea)
    `CHK(lna_reduced_gain_o, er)
    `CHK(rx_mixer_boost_o, eb)
  endtask

  // Strobe, retry mid-wait (ignored), then count cycles to the start pulse
  task automatic turnaround(input logic sel);
    int n;
    int exp_n;
    d = m[0];
    d[13] = sel;
    wr(6'h15, d);
    exp_n = (sel ? 12 : 8) * 16 * 1000 / 50;
    @(negedge mclk_i);
    transmit_on_strobe_i = 1'b1;
    @(negedge mclk_i);
    transmit_on_strobe_i = 1'b0;
    n = 0;
    while (tx_start_o !== 1'b1 && n < 5000) begin
      @(negedge mclk_i);
      n++;
      if (n == 1) `CHK(tx_waiting_o, 1'b1)
      transmit_on_strobe_i = (n == 100);
    end
    `CHK(n, exp_n)
    `CHK(tx_waiting_o, 1'b0)
    @(negedge mclk_i);
    `CHK(tx_start_o, 1'b0)
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(negedge mclk_i);
    srst_i = 1'b0;
    m[0] = {2'd2, 1'b1, 2'd0, 2'd0, 3'd3, 1'b1, 5'd31};
    m[1] = {2'd0, 2'd1, 2'd0, 2'd2, 2'd3, 2'd2, 2'd1, 2'd1};
    m[2] = {2'd0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'd1, 2'd1, 2'd1, 2'd2};
    lg = GAIN_HIGH;
    check_fields();
    for (int r = 0; r < 3; r++) rd(6'h15 + 6'(r), m[r]);
    rd(6'h14, 16'h0000);
    // Random writes across the bank and all three gain states
    for (int i = 0; i < 15; i++) begin
      rnd = lfsr_next(rnd);
      a = 6'h15 + 6'(rnd[1:0] % 2'd3);
      rnd = lfsr_next(rnd);
      d = rnd;
      if (a == 6'h15) d[5] = 1'b1;
      else d[15:14] = 2'b00;
      wr(a, d);
      rd(a, m[a - 6'h15]);
      lg = (i % 3 == 0) ? GAIN_HIGH : (i % 3 == 1) ? GAIN_MEDIUM : GAIN_LOW;
      agc_gain_state_i = lg;
      check_fields();
    end
    // A write to an unmapped place leaves the bank alone
    wr(6'h18, 16'hffff);
    for (int r = 0; r < 3; r++) rd(6'h15 + 6'(r), m[r]);
    // Every amplifier code, boundaries included
    for (int c = 0; c < 8; c++) begin
      d = m[0];
      d[8:6] = 3'(c);
      wr(6'h15, d);
      check_fields();
    end
    // Non one-hot gain code holds the previous set
    agc_gain_state_i = gain_state_t'(3'b011);
    check_fields();
    agc_gain_state_i = lg;
    wr(6'h17, m[2] | 16'h2000);
    check_fields();
    // Read and write in one cycle: the read returns the old word
    d = m[1];
    @(negedge mclk_i);
    cfg_wr_i = 1'b1;
    cfg_rd_i = 1'b1;
    cfg_addr_i = 6'h16;
    cfg_wdata_i = 16'h0a5a;
    @(negedge mclk_i);
    cfg_wr_i = 1'b0;
    model_wr(6'h16, 16'h0a5a);
    `CHK(cfg_rvalid_o, 1'b1)
    `CHK(cfg_rdata_o, d)
    // Read held for a second edge: the new word follows the write at once
    @(negedge mclk_i);
    cfg_rd_i = 1'b0;
    `CHK(cfg_rvalid_o, 1'b1)
    `CHK(cfg_rdata_o, m[1])
    rd(6'h16, m[1]);
    turnaround(1'b0);
    turnaround(1'b1);
    wrap_up();
  end

  // Hang guard, well beyond the expected run of about 6600 cycles
  initial begin
    #(20000 * 50);
    n_mismatch++;
    wrap_up();
  end

endmodule

`undef CHK
`default_nettype wire
